// *** rtl/spi_port.sv ***
// Function
// - 8-bit or 16-bit length by control bit 10
// - length change resets transfer state and counters
// - output from bit 7 or bit 15
// - input enters shift register at bit 0
// - output-disable bit releases serial data out
// - frame mode turns slave select into frame sync
// - frame direction bit selects frame pulse direction
// - frame pulse active high, one serial clock
// - shifting starts after the frame pulse
// - slave select control gates slave transfers
// - slave select high releases output, resets counters
// - reassertion restarts at most significant bit
// - sleep halts and aborts any transfer
// - sleep leaves register contents unchanged
// - stop-in-idle bit decides running in idle
// - overflow drops word, ignores clock until read
// - completion sets interrupt flag, enable masks it
// - polarity sets idle level, edge bit timing
// - master clock from quarter oscillator, two prescalers
`timescale 1ns/1ps
module spi_port (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe_b,
  input  wire logic        sdi,
  output logic             sdo_out,
  output logic             sdo_oe_b,
  input  wire logic        ss_in,
  output logic             ss_out,
  output logic             ss_oe_b,
  input  wire logic        cpu_sleep,
  input  wire logic        cpu_idle,
  output logic             port_irq
);
  logic [15:0] ctrl_reg, ctrl_next;
  logic [15:0] tx_buf_reg, tx_buf_next;
  logic [15:0] rx_buf_reg, rx_buf_next;
  logic        en_reg, en_next;
  logic        sidl_reg, sidl_next;
  logic        ovf_reg, ovf_next;
  logic        tbf_reg, tbf_next;
  logic        rbf_reg, rbf_next;
  logic        irq_flag_reg, irq_flag_next;
  logic        irq_en_reg, irq_en_next;
  logic [31:0] prdata_reg, prdata_next;
  spi_pkg::port_state_e state_reg, state_next;
  logic [4:0]  count_reg, count_next;
  logic        sck_reg, sck_next;
  logic        sck_prev_reg;
  logic        tx_bit_reg, tx_bit_next;
  logic        fs_reg, fs_next;
  logic [1:0]  sync_ticks_reg, sync_ticks_next;

  logic        master, frame, fs_in, word16, cke, clock_idle_polarity, ss_gate, ss_off;
  logic        run, active, tick, lead, trail, tx_edge, rx_edge;
  logic        done, shift, load, clr, wl_change, sr_msb;
  logic [4:0]  len;
  logic [15:0] sr;
  logic [3:0]  wsel, rsel;
  logic        wr_en, rd_acc, setup;

  function automatic logic [3:0] reg_sel(input logic [11:0] a);
    reg_sel = {a == spi_pkg::IRQ_ADDR, a == spi_pkg::BUF_ADDR,
               a == spi_pkg::CTRL_ADDR, a == spi_pkg::STAT_ADDR};
  endfunction : reg_sel

  assign master  = ctrl_reg[spi_pkg::CT_MST];
  assign frame   = ctrl_reg[spi_pkg::CT_FRM];
  assign fs_in   = ctrl_reg[spi_pkg::CT_FSD];
  assign word16  = ctrl_reg[spi_pkg::CT_W16];
  assign cke     = ctrl_reg[spi_pkg::CT_CKE];
  assign clock_idle_polarity     = ctrl_reg[spi_pkg::CT_CKP];
  assign len     = word16 ? spi_pkg::BITS16 : spi_pkg::BITS8;
  assign ss_gate = !master && !frame && ctrl_reg[spi_pkg::CT_SLAVE_SELECT_CONTROL_ENABLE];
  assign ss_off  = ss_gate && ss_in;
  // idle stop, sleep and overflow hold all freeze the serial side
  assign run     = en_reg && !cpu_sleep && !(cpu_idle && sidl_reg)
                   && !(ovf_reg && rbf_reg);
  assign active  = state_reg != spi_pkg::ST_IDLE;

  sck_prescaler u_presc (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .run       (run && master && active),
    .primary   (ctrl_reg[spi_pkg::CT_PRIMARY_PRESCALE +: 2]),
    .secondary (ctrl_reg[spi_pkg::CT_SECONDARY_PRESCALE +: 3]),
    .tick      (tick)
  );

  // leading edge leaves idle level, trailing edge returns to it
  always_comb begin
    if (master) begin
      lead  = tick && (sck_reg == clock_idle_polarity) && (count_reg != len);
      trail = tick && (sck_reg != clock_idle_polarity);
    end else begin
      lead  = run && (sck_in != clock_idle_polarity) && (sck_prev_reg == clock_idle_polarity);
      trail = run && (sck_in == clock_idle_polarity) && (sck_prev_reg != clock_idle_polarity);
    end
    tx_edge = cke ? trail : lead;
    rx_edge = cke ? lead : trail;
  end

  assign setup     = psel && !penable;
  assign wsel      = reg_sel(paddr);
  assign rsel      = wsel;
  assign wr_en     = psel && penable && pwrite;
  assign rd_acc    = psel && penable && !pwrite;
  assign wl_change = wr_en && wsel[1] && (pwdata[spi_pkg::CT_W16] != word16);
  assign shift     = run && !ss_off && (state_reg == spi_pkg::ST_SHIFT)
                     && rx_edge && (count_reg < len);
  assign done      = (state_reg == spi_pkg::ST_SHIFT) && (count_reg == len)
                     && (!master || sck_reg == clock_idle_polarity);
  assign load      = tbf_reg && !wl_change &&
                     ((state_reg == spi_pkg::ST_IDLE && run && !ss_off) || done);
  assign clr       = wl_change;

  word_shifter u_shift (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .clr       (clr),
    .load      (load),
    .load_data (tx_buf_reg),
    .shift     (shift),
    .sdi       (sdi),
    .word16    (word16),
    .sr        (sr),
    .msb       (sr_msb)
  );

  always_comb begin
    ctrl_next       = ctrl_reg;
    tx_buf_next     = tx_buf_reg;
    rx_buf_next     = rx_buf_reg;
    en_next         = en_reg;
    sidl_next       = sidl_reg;
    ovf_next        = ovf_reg;
    tbf_next        = tbf_reg;
    rbf_next        = rbf_reg;
    irq_flag_next   = irq_flag_reg;
    irq_en_next     = irq_en_reg;
    state_next      = state_reg;
    count_next      = count_reg;
    sck_next        = sck_reg;
    tx_bit_next     = tx_bit_reg;
    fs_next         = fs_reg;
    sync_ticks_next = sync_ticks_reg;
    prdata_next     = prdata_reg;

    // register reads, captured in the setup cycle
    if (setup && !pwrite) begin
      prdata_next = 32'h0000_0000;
      unique case (1'b1)
        rsel[0]: begin
          prdata_next[spi_pkg::ST_EN]   = en_reg;
          prdata_next[spi_pkg::ST_SIDL] = sidl_reg;
          prdata_next[spi_pkg::ST_ROV]  = ovf_reg;
          prdata_next[spi_pkg::ST_TBF]  = tbf_reg;
          prdata_next[spi_pkg::ST_RBF]  = rbf_reg;
        end
        rsel[1]: prdata_next[15:0] = ctrl_reg;
        rsel[2]: prdata_next[15:0] = rx_buf_reg;
        rsel[3]: begin
          prdata_next[spi_pkg::IR_FLAG] = irq_flag_reg;
          prdata_next[spi_pkg::IR_EN]   = irq_en_reg;
        end
        default: prdata_next = 32'h0000_0000;
      endcase
    end
    if (rd_acc && rsel[2]) begin
      rbf_next = 1'b0;
    end
    if (wr_en) begin
      if (wsel[0]) begin
        en_next   = pwdata[spi_pkg::ST_EN];
        sidl_next = pwdata[spi_pkg::ST_SIDL];
        if (!pwdata[spi_pkg::ST_ROV]) begin
          ovf_next = 1'b0;
        end
      end
      if (wsel[1]) begin
        ctrl_next = {1'b0, pwdata[14:13], 1'b0, pwdata[11:0]};
      end
      if (wsel[2]) begin
        tx_buf_next = pwdata[15:0];
        tbf_next    = 1'b1;
      end
      if (wsel[3]) begin
        irq_en_next = pwdata[spi_pkg::IR_EN];
        if (pwdata[spi_pkg::IR_FLAG]) begin
          irq_flag_next = 1'b0;
        end
      end
    end

    if (load) begin
      tbf_next    = wr_en && wsel[2];
      tx_bit_next = word16 ? tx_buf_reg[15] : tx_buf_reg[7];
    end
    if (master && tick) begin
      sck_next = !sck_reg;
    end
    if (!master) begin
      sck_next = clock_idle_polarity;
    end

    unique case (state_reg)
      spi_pkg::ST_IDLE: begin
        count_next = 5'h00;
        if (run && !ss_off && (!master || tbf_reg)) begin
          state_next      = frame ? spi_pkg::ST_SYNC : spi_pkg::ST_SHIFT;
          fs_next         = frame && master && !fs_in;
          sync_ticks_next = 2'h0;
          sck_next        = clock_idle_polarity;
        end
      end
      spi_pkg::ST_SYNC: begin
        if (!fs_in) begin
          // own pulse spans one whole serial clock
          if (tick) begin
            sync_ticks_next = sync_ticks_reg + 2'h1;
          end
          if (tick && sync_ticks_reg == 2'h1) begin
            fs_next    = 1'b0;
            state_next = spi_pkg::ST_SHIFT;
          end
        end else if (lead && ss_in) begin
          state_next = spi_pkg::ST_SHIFT;
        end
      end
      spi_pkg::ST_SHIFT: begin
        if (tx_edge && run && count_reg < len) begin
          tx_bit_next = sr_msb;
        end
        if (shift) begin
          count_next = count_reg + 5'h01;
        end
        if (done) begin
          count_next    = 5'h00;
          irq_flag_next = 1'b1;
          if (rbf_reg && !(rd_acc && rsel[2])) begin
            ovf_next = 1'b1;
          end else begin
            rx_buf_next = sr;
            rbf_next    = 1'b1;
          end
          if (master && !tbf_reg) begin
            state_next = spi_pkg::ST_IDLE;
          end else if (frame) begin
            state_next      = spi_pkg::ST_SYNC;
            fs_next         = master && !fs_in;
            sync_ticks_next = 2'h0;
          end
        end
      end
      default: state_next = spi_pkg::ST_IDLE;
    endcase

    // slave select high: resync, next frame starts at the top bit
    if (ss_off) begin
      state_next  = spi_pkg::ST_IDLE;
      count_next  = 5'h00;
      tx_bit_next = sr_msb;
    end
    // sleep or disable abort the transfer, registers kept
    if (cpu_sleep || !en_reg) begin
      state_next = spi_pkg::ST_IDLE;
      count_next = 5'h00;
      fs_next    = 1'b0;
      sck_next   = clock_idle_polarity;
    end
    if (wl_change) begin
      state_next = spi_pkg::ST_IDLE;
      count_next = 5'h00;
      fs_next    = 1'b0;
      tbf_next   = 1'b0;
      rbf_next   = 1'b0;
      ovf_next   = 1'b0;
      sck_next   = pwdata[spi_pkg::CT_CKP];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg       <= spi_pkg::CTRL_RST;
      tx_buf_reg     <= spi_pkg::BUF_RST;
      rx_buf_reg     <= spi_pkg::BUF_RST;
      en_reg         <= 1'b0;
      sidl_reg       <= 1'b0;
      ovf_reg        <= 1'b0;
      tbf_reg        <= 1'b0;
      rbf_reg        <= 1'b0;
      irq_flag_reg   <= 1'b0;
      irq_en_reg     <= 1'b0;
      prdata_reg     <= 32'h0000_0000;
      state_reg      <= spi_pkg::ST_IDLE;
      count_reg      <= 5'h00;
      sck_reg        <= 1'b0;
      sck_prev_reg   <= 1'b0;
      tx_bit_reg     <= 1'b0;
      fs_reg         <= 1'b0;
      sync_ticks_reg <= 2'h0;
    end else begin
      ctrl_reg       <= ctrl_next;
      tx_buf_reg     <= tx_buf_next;
      rx_buf_reg     <= rx_buf_next;
      en_reg         <= en_next;
      sidl_reg       <= sidl_next;
      ovf_reg        <= ovf_next;
      tbf_reg        <= tbf_next;
      rbf_reg        <= rbf_next;
      irq_flag_reg   <= irq_flag_next;
      irq_en_reg     <= irq_en_next;
      prdata_reg     <= prdata_next;
      state_reg      <= state_next;
      count_reg      <= count_next;
      sck_reg        <= sck_next;
      sck_prev_reg   <= sck_in;
      tx_bit_reg     <= tx_bit_next;
      fs_reg         <= fs_next;
      sync_ticks_reg <= sync_ticks_next;
    end
  end

  assign prdata   = prdata_reg;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && (wsel == 4'h0);
  assign port_irq = irq_flag_reg && irq_en_reg;
  assign sck_out  = sck_reg;
  assign sck_oe_b = !(en_reg && master);
  assign sdo_out  = tx_bit_reg;
  assign sdo_oe_b = !(en_reg && !cpu_sleep && !ctrl_reg[spi_pkg::CT_DIS] && !ss_off);
  assign ss_out   = fs_reg;
  assign ss_oe_b  = !(en_reg && frame && !fs_in);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_len_bound:    assert property (count_reg <= len)
    else $error("bit count beyond word length");
  a_wl_reset:     assert property (wl_change |=> count_reg == 5'h00 && !tbf_reg
                                    && state_reg == spi_pkg::ST_IDLE)
    else $error("length change did not reset port");
  a_sdo_msb:      assert property (tx_edge && run && !ss_off && count_reg < len
                                    && state_reg == spi_pkg::ST_SHIFT && !load
                                    |=> sdo_out == $past(sr_msb))
    else $error("serial out not from top bit");
  a_sdo_disable:  assert property (ctrl_reg[spi_pkg::CT_DIS] |-> sdo_oe_b)
    else $error("serial out driven while disabled");
  a_frame_quiet:  assert property (state_reg == spi_pkg::ST_SHIFT |-> !ss_out)
    else $error("frame pulse during data");
  a_frame_start:  assert property (state_reg == spi_pkg::ST_SYNC |-> count_reg == 5'h00)
    else $error("shifting before frame pulse");
  a_ss_release:   assert property (en_reg && ss_off |=> count_reg == 5'h00
                                    && state_reg == spi_pkg::ST_IDLE)
    else $error("slave select high did not resync");
  a_ss_drive:     assert property (ss_off |-> sdo_oe_b)
    else $error("serial out driven while deselected");
  a_sleep_abort:  assert property (cpu_sleep |=> state_reg == spi_pkg::ST_IDLE
                                    ##1 state_reg == spi_pkg::ST_IDLE)
    else $error("transfer survived sleep");
  a_sleep_keep:   assert property (cpu_sleep && !wr_en |=> $stable(ctrl_reg)
                                    && $stable(tx_buf_reg))
    else $error("sleep altered registers");
  a_idle_stop:    assert property (cpu_idle && sidl_reg |=> $stable(count_reg))
    else $error("port ran in idle with stop bit set");
  a_ovf_drop:     assert property (done && rbf_reg && !rd_acc |=> ovf_reg
                                    && $stable(rx_buf_reg))
    else $error("overflow word not dropped");
  a_irq_done:     assert property (done |=> irq_flag_reg)
    else $error("completion did not flag");

  c_word16:  cover property (done && word16);
  c_frame:   cover property (done && frame && master);
  c_ovf:     cover property ($rose(ovf_reg));
  c_resync:  cover property (ss_off && count_reg != 5'h00);
endmodule : spi_port

// *** rtl/spi_pkg.sv ***
package spi_pkg;
  // register indices and their byte addresses
  localparam logic [11:0] STAT_IDX  = 12'h220;
  localparam logic [11:0] CTRL_IDX  = 12'h222;
  localparam logic [11:0] BUF_IDX   = 12'h224;
  localparam logic [11:0] IRQ_IDX   = 12'h230;
  localparam logic [11:0] STAT_ADDR = {STAT_IDX[9:0], 2'b00};
  localparam logic [11:0] CTRL_ADDR = {CTRL_IDX[9:0], 2'b00};
  localparam logic [11:0] BUF_ADDR  = {BUF_IDX[9:0], 2'b00};
  localparam logic [11:0] IRQ_ADDR  = {IRQ_IDX[9:0], 2'b00};
  // status fields
  localparam int ST_EN   = 15;
  localparam int ST_SIDL = 13;
  localparam int ST_ROV  = 6;
  localparam int ST_TBF  = 1;
  localparam int ST_RBF  = 0;
  // control fields
  localparam int CT_FRM  = 14;
  localparam int CT_FSD  = 13;
  localparam int CT_DIS  = 11;
  localparam int CT_W16  = 10;
  localparam int CT_SMP  = 9;
  localparam int CT_CKE  = 8;
  localparam int CT_SLAVE_SELECT_CONTROL_ENABLE = 7;
  localparam int CT_CKP  = 6;
  localparam int CT_MST  = 5;
  localparam int CT_SECONDARY_PRESCALE = 2;
  localparam int CT_PRIMARY_PRESCALE = 0;
  // interrupt register fields
  localparam int IR_FLAG = 0;
  localparam int IR_EN   = 1;
  // reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] BUF_RST  = 16'h0000;
  // bit counts and clock divide
  localparam logic [4:0]  BITS8    = 5'h08;
  localparam logic [4:0]  BITS16   = 5'h10;
  localparam logic [10:0] FOSC_DIV = 11'h004;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SYNC  = 3'b010,
    ST_SHIFT = 3'b100
  } port_state_e;
endpackage : spi_pkg

// *** rtl/sck_prescaler.sv ***
`timescale 1ns/1ps
module sck_prescaler (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       run,
  input  wire logic [1:0] primary,
  input  wire logic [2:0] secondary,
  output logic            tick
);
  logic [10:0] cnt_reg;
  logic [10:0] cnt_next;
  logic [10:0] half;

  function automatic logic [10:0] pri_div(input logic [1:0] code);
    unique case (code)
      2'h3: pri_div = 11'h001;
      2'h2: pri_div = 11'h004;
      2'h1: pri_div = 11'h010;
      2'h0: pri_div = 11'h040;
    endcase
  endfunction : pri_div

  // half sck period: quarter of core clock, then both prescalers
  always_comb begin
    half     = 11'((spi_pkg::FOSC_DIV >> 1) * pri_div(primary) * (11'h008 - 11'(secondary)));
    tick     = run && (cnt_reg == 11'h000);
    cnt_next = cnt_reg;
    if (!run || tick) begin
      cnt_next = half - 11'h001;
    end else begin
      cnt_next = cnt_reg - 11'h001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 11'h000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule : sck_prescaler

// *** rtl/word_shifter.sv ***
`timescale 1ns/1ps
module word_shifter (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        clr,
  input  wire logic        load,
  input  wire logic [15:0] load_data,
  input  wire logic        shift,
  input  wire logic        sdi,
  input  wire logic        word16,
  output logic [15:0]      sr,
  output logic             msb
);
  logic [15:0] sr_reg;
  logic [15:0] sr_next;

  always_comb begin
    sr_next = sr_reg;
    if (clr) begin
      sr_next = 16'h0000;
    end else if (load) begin
      sr_next = word16 ? load_data : {8'h00, load_data[7:0]};
    end else if (shift) begin
      // new bits enter at bit 0; upper byte idle in 8-bit length
      sr_next = word16 ? {sr_reg[14:0], sdi} : {8'h00, sr_reg[6:0], sdi};
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sr_reg <= 16'h0000;
    end else begin
      sr_reg <= sr_next;
    end
  end

  assign sr  = sr_reg;
  assign msb = word16 ? sr_reg[15] : sr_reg[7];
endmodule : word_shifter

// *** dv/spi_partner.sv ***
`timescale 1ns/1ps
module spi_partner (
  input  wire logic core_clk,
  input  wire logic sck_out,
  input  wire logic sdo_out,
  input  wire logic ss_out,
  output logic      sck_in,
  output logic      sdi,
  output logic      ss_in
);
  localparam int HALF = 6;
  logic [15:0] tx_word;
  logic [15:0] cap_word;
  int          idx;
  logic        slave_on;
  logic        skip;
  initial begin
    sck_in   = 1'b0;
    ss_in    = 1'b1;
    sdi      = 1'b0;
    slave_on = 1'b0;
    skip     = 1'b0;
    cap_word = 16'h0000;
    tx_word  = 16'h0000;
    idx      = 0;
  end
  // far-side slave: present msb before the first clock
  task automatic arm(input logic [15:0] w, input int n);
    tx_word  = w;
    idx      = n - 1;
    cap_word = 16'h0000;
    slave_on = 1'b1;
    sdi <= w[n-1];
  endtask : arm
  // clock cycle under the frame pulse carries no data
  always @(posedge sck_out) begin
    skip = ss_out;
  end
  // next bit after each trailing edge
  always @(negedge sck_out) begin
    if (slave_on && !skip) begin
      cap_word = {cap_word[14:0], sdo_out};
      idx = idx - 1;
      if (idx >= 0) sdi <= tx_word[idx];
      else slave_on = 1'b0;
    end
  end
  // released data line shows no stale value
  always @(negedge core_clk) begin
    if (!slave_on && ss_in) sdi = ~sdi;
  end
  // far-side master, msb first; cut bits then select released
  task automatic xfer(input logic [15:0] w, input int n, input int cut);
    int i;
    slave_on = 1'b0;
    cap_word = 16'h0000;
    ss_in <= 1'b0;
    repeat (HALF) @(posedge core_clk);
    for (i = n - 1; i >= n - cut; i--) begin
      sdi <= w[i];
      repeat (HALF) @(posedge core_clk);
      sck_in <= 1'b1;
      repeat (HALF) @(posedge core_clk);
      sck_in <= 1'b0;
      cap_word = {cap_word[14:0], sdo_out};
      repeat (HALF) @(posedge core_clk);
    end
    ss_in <= 1'b1;
    repeat (HALF) @(posedge core_clk);
  endtask : xfer
endmodule : spi_partner

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [31:0] exp;
    logic [31:0] mask;
    logic        err;
  } note_s;
  logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic        cpu_sleep, cpu_idle, port_irq, sck_in, sck_out, sck_oe_b, sdi;
  logic        sdo_out, sdo_oe_b, ss_in, ss_out, ss_oe_b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] w0, w1;
  note_s       notes[$];
  note_s       cur;
  int          miscompares, check_count, cycles;
  integer      seed;
  spi_port spi_port_inst (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck_in(sck_in), .sck_out(sck_out), .sck_oe_b(sck_oe_b), .sdi(sdi),
    .sdo_out(sdo_out), .sdo_oe_b(sdo_oe_b), .ss_in(ss_in), .ss_out(ss_out),
    .ss_oe_b(ss_oe_b), .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle), .port_irq(port_irq));
  spi_partner spi_partner_inst (.core_clk(core_clk), .sck_out(sck_out), .sdo_out(sdo_out),
    .ss_out(ss_out), .sck_in(sck_in), .sdi(sdi), .ss_in(ss_in));
  always #2 core_clk = ~core_clk;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  // completed access: oldest note against read data and error
  always @(posedge core_clk) begin
    if (psel && penable && pready) begin
      cur = notes.pop_front();
      check_count++;
      if (((prdata & cur.mask) !== (cur.exp & cur.mask)) || (pslverr !== cur.err)) begin
        miscompares++;
        $display("MISMATCH t=%0t addr %h got %h exp %h", $time, paddr, prdata, cur.exp);
      end
    end
  end
  task automatic pin(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t pin got %h exp %h", $time, got, exp);
    end
  endtask : pin
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m, input logic err);
    notes.push_back('{e, m, err});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0000, d}, 32'h0, 32'h0, 1'b0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [15:0] e, input logic [15:0] m);
    apb(1'b0, a, 32'h0, {16'h0000, e}, {16'hffff, m}, 1'b0);
  endtask : rd
  task automatic cfg(input logic [15:0] c, input logic [15:0] s);
    wr(spi_pkg::STAT_ADDR, 16'h0000);
    wr(spi_pkg::CTRL_ADDR, c);
    wr(spi_pkg::STAT_ADDR, s);
    wr(spi_pkg::IRQ_ADDR, 16'h0003);
  endtask : cfg
  task automatic irq_done();
    int k;
    k = 0;
    while (port_irq !== 1'b1 && k < 600) begin
      @(posedge core_clk);
      k++;
    end
    pin(port_irq, 1'b1);
  endtask : irq_done
  task automatic mx(input logic [15:0] c, input logic [15:0] s, input int hold);
    logic [15:0] tw, rw, m;
    int          n, k, hi;
    n  = c[spi_pkg::CT_W16] ? 16 : 8;
    m  = c[spi_pkg::CT_W16] ? 16'hffff : 16'h00ff;
    tw = $random(seed);
    rw = $random(seed);
    hi = 0;
    cfg(c, s);
    spi_partner_inst.arm(rw, n);
    wr(spi_pkg::BUF_ADDR, tw);
    for (k = 0; k < 12; k++) begin
      @(negedge core_clk);
      if (ss_out === 1'b1) hi++;
    end
    @(posedge core_clk);
    pin(16'(hi), c[spi_pkg::CT_FRM] ? 16'h0004 : 16'h0000);
    pin(ss_oe_b, !c[spi_pkg::CT_FRM]);
    pin(sdo_oe_b, c[spi_pkg::CT_DIS]);
    if (hold > 0) begin
      repeat (hold) @(posedge core_clk);
      pin(port_irq, 1'b0);
      cpu_idle <= 1'b0;
    end
    irq_done();
    rd(spi_pkg::BUF_ADDR, rw & m, 16'hffff);
    if (!c[spi_pkg::CT_DIS]) pin(spi_partner_inst.cap_word & m, tw & m);
    wr(spi_pkg::IRQ_ADDR, 16'h0000);
    pin(port_irq, 1'b0);
    rd(spi_pkg::IRQ_ADDR, 16'h0001, 16'hffff);
    wr(spi_pkg::IRQ_ADDR, 16'h0003);
    pin(port_irq, 1'b0);
  endtask : mx
  task automatic sl(input logic [15:0] c, input logic [15:0] rw, input int cut, input logic so);
    logic [15:0] tw, m;
    int          n;
    n  = c[spi_pkg::CT_W16] ? 16 : 8;
    m  = c[spi_pkg::CT_W16] ? 16'hffff : 16'h00ff;
    tw = $random(seed);
    wr(spi_pkg::BUF_ADDR, tw);
    pin(sdo_oe_b, 1'b1);
    if (cut > 0) spi_partner_inst.xfer(~rw, n, cut);
    pin(sdo_oe_b, 1'b1);
    spi_partner_inst.xfer(rw, n, n);
    irq_done();
    if (so) pin(spi_partner_inst.cap_word & m, tw & m);
  endtask : sl
  initial begin
    core_clk  = 1'b0;
    rst_b     = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    cpu_sleep = 1'b0;
    cpu_idle  = 1'b0;
    seed      = 32'h3feccd67;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rd(spi_pkg::STAT_ADDR, 16'h0000, 16'hffff);
    rd(spi_pkg::CTRL_ADDR, spi_pkg::CTRL_RST, 16'hffff);
    rd(spi_pkg::BUF_ADDR, spi_pkg::BUF_RST, 16'hffff);
    pin({sdo_oe_b, sck_oe_b, ss_oe_b}, 16'h0007);
    apb(1'b1, 12'h004, 32'h0000ffff, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 12'h004, 32'h0, 32'h0, 32'hffffffff, 1'b1);
    wr(spi_pkg::CTRL_ADDR, 16'hffff);
    rd(spi_pkg::CTRL_ADDR, 16'h6fff, 16'hffff);
    wr(spi_pkg::STAT_ADDR, 16'hffff);
    rd(spi_pkg::STAT_ADDR, 16'ha000, 16'hffff);
    mx(16'h003f, 16'h8000, 0);
    mx(16'h043f, 16'h8000, 0);
    mx(16'h0836, 16'h8000, 0);
    mx(16'h403f, 16'h8000, 0);
    cpu_idle <= 1'b1;
    mx(16'h003f, 16'h8000, 0);
    cpu_idle <= 1'b1;
    mx(16'h003f, 16'ha000, 60);
    cfg(16'h603f, 16'h8000);
    pin(ss_oe_b, 1'b1);
    cfg(16'h043f, 16'h8000);
    spi_partner_inst.arm(16'ha5a5, 16);
    wr(spi_pkg::BUF_ADDR, 16'h1234);
    repeat (8) @(posedge core_clk);
    cpu_sleep <= 1'b1;
    repeat (3) @(posedge core_clk);
    pin(sdo_oe_b, 1'b1);
    repeat (80) @(posedge core_clk);
    pin(port_irq, 1'b0);
    rd(spi_pkg::CTRL_ADDR, 16'h043f, 16'hffff);
    cpu_sleep <= 1'b0;
    @(posedge core_clk);
    rd(spi_pkg::STAT_ADDR, 16'h8000, 16'hfffd);
    w0 = $random(seed);
    w1 = $random(seed);
    cfg(16'h0080, 16'h8000);
    sl(16'h0080, w0, 0, 1'b1);
    rd(spi_pkg::BUF_ADDR, w0 & 16'h00ff, 16'hffff);
    cfg(16'h0480, 16'h8000);
    sl(16'h0480, w1, 5, 1'b0);
    rd(spi_pkg::BUF_ADDR, w1, 16'hffff);
    cfg(16'h0080, 16'h8000);
    sl(16'h0080, w1, 0, 1'b1);
    sl(16'h0080, w0, 0, 1'b0);
    rd(spi_pkg::STAT_ADDR, 16'h8041, 16'h0041);
    rd(spi_pkg::BUF_ADDR, w1 & 16'h00ff, 16'hffff);
    wrap_up();
  end
endmodule : tb_top
